//--- hw/vidmx_top.sv
// vidmx_top: input port mapping, demultiplexer and register port
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module vidmx_top (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // register port
  input  wire logic [vidmx_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [vidmx_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [vidmx_pkg::DATA_W-1:0]        reg_rdata_q,
  // data ports, first group
  input  wire logic [vidmx_pkg::PORT_W-1:0]   port_p1,
  input  wire logic [vidmx_pkg::PORT_W-1:0]   port_p2,
  input  wire logic [vidmx_pkg::PORT_W-1:0]   port_p3,
  input  wire logic [vidmx_pkg::NARROW_W-1:0] port_p4,
  // data ports, second group
  input  wire logic [vidmx_pkg::PORT_W-1:0]   port_p5,
  input  wire logic [vidmx_pkg::PORT_W-1:0]   port_p6,
  input  wire logic [vidmx_pkg::PORT_W-1:0]   port_p7,
  input  wire logic [vidmx_pkg::NARROW_W-1:0] port_p8,
  // timing strobes
  input  wire logic                           chroma_phase_sync,
  input  wire logic                           line_blank,
  // processed channels
  output logic                                ch_valid_q,
  output logic [vidmx_pkg::SMP_W-1:0]         ch_luma_q,
  output logic [vidmx_pkg::SMP_W-1:0]         ch_blue_q,
  output logic [vidmx_pkg::SMP_W-1:0]         ch_red_q,
  output logic [vidmx_pkg::SMP_W-1:0]         ch_key_q,
  // control to downstream stages
  output logic                                timing_flag_out_en_q
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [vidmx_pkg::CTRL_W-1:0] ctrl_q;       // control register
  logic                         aligned_q;    // a sync edge was seen
  logic [1:0]                   phase_q;      // demux sample phase
  vidmx_pkg::vidmx_fmt_t        fmt;          // decoded format

  logic input_muxed_sel;
  logic input_link_count_sel;
  logic port_dir_sel;
  logic alt_sync_timing;
  logic blank_level_sel_hi;
  logic blank_level_sel_lo;

  assign input_muxed_sel      = ctrl_q[vidmx_pkg::CTRL_MUXED];
  assign input_link_count_sel = ctrl_q[vidmx_pkg::CTRL_LINK];
  assign port_dir_sel         = ctrl_q[vidmx_pkg::CTRL_PORTDIR];
  assign alt_sync_timing      = ctrl_q[vidmx_pkg::CTRL_ALTSYNC];
  assign blank_level_sel_hi   = ctrl_q[vidmx_pkg::CTRL_BLK_HI];
  assign blank_level_sel_lo   = ctrl_q[vidmx_pkg::CTRL_BLK_LO];

  // control write; software is trusted to keep the muxed bit low in
  // single link and alt timing low for single link, nothing is forced
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= vidmx_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == vidmx_pkg::REG_CTRL) begin
      ctrl_q <= reg_wdata[vidmx_pkg::CTRL_W-1:0];
    end
  end

  // downstream output-flag enable is carried as a plain register bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timing_flag_out_en_q <= 1'b0;
    end else begin
      timing_flag_out_en_q <= ctrl_q[vidmx_pkg::CTRL_HVF];
    end
  end

  // read data stands one cycle after the read strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        vidmx_pkg::REG_CTRL: begin
          reg_rdata_q <= {1'b0, ctrl_q};
        end
        vidmx_pkg::REG_STATUS: begin
          reg_rdata_q <= {3'h0, fmt, aligned_q, phase_q};
        end
        default: begin
          reg_rdata_q <= 8'h00;  // unmapped reads as zero
        end
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // format decode
  // ------------------------------------------------------------
  // muxed high wins regardless of the link bit
  always_comb begin
    if (input_muxed_sel) begin
      fmt = vidmx_pkg::FMT_NON_MUX;
    end else if (input_link_count_sel) begin
      fmt = vidmx_pkg::FMT_SINGLE_MUX;
    end else begin
      fmt = vidmx_pkg::FMT_DUAL_MUX;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // data and strobes share two stages so they stay aligned
  logic [vidmx_pkg::SMP_W-1:0] lane_s1_q [4];  // first stage
  logic [vidmx_pkg::SMP_W-1:0] lane_s2_q [4];  // second stage
  logic [vidmx_pkg::SMP_W-1:0] lane_pin  [4];  // selected port group
  logic [2:0]                  sync_q;        // sync: two stages and history
  logic [1:0]                  blank_s_q;     // blank: two stages
  logic                        blank_d_q;     // blank aligned to demux

  // port group pick; bits 12..10 are dropped, 8-bit data already sits in 9..2
  always_comb begin
    if (port_dir_sel) begin
      lane_pin[0] = port_p5[vidmx_pkg::SMP_W-1:0];
      lane_pin[1] = port_p6[vidmx_pkg::SMP_W-1:0];
      lane_pin[2] = port_p7[vidmx_pkg::SMP_W-1:0];
      lane_pin[3] = port_p8[vidmx_pkg::SMP_W-1:0];
    end else begin
      lane_pin[0] = port_p1[vidmx_pkg::SMP_W-1:0];
      lane_pin[1] = port_p2[vidmx_pkg::SMP_W-1:0];
      lane_pin[2] = port_p3[vidmx_pkg::SMP_W-1:0];
      lane_pin[3] = port_p4[vidmx_pkg::SMP_W-1:0];
    end
  end

  // one two-stage synchroniser per core lane
  for (genvar i = 0; i < 4; i++) begin : g_lane
    always_ff @(posedge clk) begin
      if (!rstn) begin
        lane_s1_q[i] <= 10'h000;
        lane_s2_q[i] <= 10'h000;
      end else begin
        lane_s1_q[i] <= lane_pin[i];
        lane_s2_q[i] <= lane_s1_q[i];
      end
    end
  end

  // strobe synchronisers; only the second stage and the sync history stage are looked at
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_q    <= 3'h0;
      blank_s_q <= 2'h0;
      blank_d_q <= 1'b0;
    end else begin
      sync_q    <= {sync_q[1:0], chroma_phase_sync};
      blank_s_q <= {blank_s_q[0], line_blank};
      blank_d_q <= blank_s_q[1];
    end
  end

  // ------------------------------------------------------------
  // phase alignment
  // ------------------------------------------------------------
  logic sync_fall;  // sync high-to-low, same cycle as the even blue sample
  logic sync_rise;  // sync low-to-high, used by the alternate timing
  logic realign;    // phase restart request

  assign sync_fall = sync_q[2] & ~sync_q[1];
  assign sync_rise = ~sync_q[2] & sync_q[1];
  // alternate timing takes the coprocessor line sync, whose rising edge
  // marks the blue sample; only meaningful for 4:2:2 or dual link
  assign realign = alt_sync_timing ? sync_rise : sync_fall;

  // phase counts freely and is held in step until the next edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_q <= vidmx_pkg::PH_CB;
    end else if (realign) begin
      phase_q <= vidmx_pkg::PH_Y0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // the edge sample itself is phase zero
  logic [1:0] phase;
  assign phase = realign ? vidmx_pkg::PH_CB : phase_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aligned_q <= 1'b0;
    end else if (realign) begin
      aligned_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // demultiplexer
  // ------------------------------------------------------------
  logic [vidmx_pkg::SMP_W-1:0] cb_q;    // latest blue chroma
  logic [vidmx_pkg::SMP_W-1:0] cr_q;    // latest red chroma
  logic [vidmx_pkg::SMP_W-1:0] y_q;     // latest luma, single link
  logic [vidmx_pkg::SMP_W-1:0] dm_luma_q;
  logic [vidmx_pkg::SMP_W-1:0] dm_blue_q;
  logic [vidmx_pkg::SMP_W-1:0] dm_red_q;
  logic [vidmx_pkg::SMP_W-1:0] dm_key_q;
  logic                        dm_valid_q;

  // chroma and luma capture from lane one by phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cb_q <= 10'h000;
      cr_q <= 10'h000;
      y_q  <= 10'h000;
    end else if (fmt != vidmx_pkg::FMT_NON_MUX) begin
      unique case (phase)
        vidmx_pkg::PH_CB: begin
          cb_q <= lane_s2_q[0];
        end
        vidmx_pkg::PH_Y0: begin
          y_q <= lane_s2_q[0];
        end
        vidmx_pkg::PH_CR: begin
          cr_q <= lane_s2_q[0];
        end
        vidmx_pkg::PH_Y1: begin
          y_q <= lane_s2_q[0];
        end
      endcase
    end
  end

  // channel assembly; a luma slot completes a pixel in dual link,
  // the fourth slot completes one in single link
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dm_valid_q <= 1'b0;
      dm_luma_q  <= 10'h000;
      dm_blue_q  <= 10'h000;
      dm_red_q   <= 10'h000;
      dm_key_q   <= 10'h000;
    end else begin
      unique case (fmt)
        vidmx_pkg::FMT_NON_MUX: begin
          dm_valid_q <= 1'b1;
          dm_luma_q  <= lane_s2_q[0];
          dm_blue_q  <= lane_s2_q[1];
          dm_red_q   <= lane_s2_q[2];
          dm_key_q   <= lane_s2_q[3];
        end
        vidmx_pkg::FMT_SINGLE_MUX: begin
          dm_valid_q <= (phase == vidmx_pkg::PH_Y1);
          dm_luma_q  <= y_q;
          dm_blue_q  <= cb_q;
          dm_red_q   <= cr_q;
          dm_key_q   <= lane_s2_q[0];
        end
        default: begin
          dm_valid_q <= phase[0];
          dm_luma_q  <= lane_s2_q[0];
          dm_blue_q  <= cb_q;
          dm_red_q   <= (phase == vidmx_pkg::PH_Y1) ? cr_q : dm_red_q;
          dm_key_q   <= lane_s2_q[3];
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // blanking stage
  // ------------------------------------------------------------
  // demux output goes straight into blanking before anything else
  vidmx_blank u_blank (
    .clk         (clk),
    .rstn        (rstn),
    .level_sel   ({blank_level_sel_hi, blank_level_sel_lo}),
    .blank       (blank_d_q),
    .in_valid    (dm_valid_q),
    .in_luma     (dm_luma_q),
    .in_blue     (dm_blue_q),
    .in_red      (dm_red_q),
    .in_key      (dm_key_q),
    .out_valid_q (ch_valid_q),
    .out_luma_q  (ch_luma_q),
    .out_blue_q  (ch_blue_q),
    .out_red_q   (ch_red_q),
    .out_key_q   (ch_key_q)
  );

endmodule

//--- hw/vidmx_pkg.sv
// vidmx_pkg: constants for the video input demux and blanking front end
package vidmx_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PORT_W   = 13;  // full data port width
  localparam int NARROW_W = 11;  // width of the fourth port of a group
  localparam int SMP_W    = 10;  // sample width inside the core
  localparam int ADDR_W   = 4;   // register address width
  localparam int DATA_W   = 8;   // register data width

  // ------------------------------------------------------------
  // clock
  // ------------------------------------------------------------
  localparam int CLK_MHZ       = 100;  // system clock rate
  localparam int LINK_CLK_MHZ  = 54;   // single-link input clock rate

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;  // control
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;  // status, read only

  // control field positions
  localparam int CTRL_MUXED   = 0;  // input_muxed_sel
  localparam int CTRL_LINK    = 1;  // input_link_count_sel
  localparam int CTRL_PORTDIR = 2;  // port-direction select
  localparam int CTRL_ALTSYNC = 3;  // alt_sync_timing
  localparam int CTRL_BLK_LO  = 4;  // blank_level_sel_lo
  localparam int CTRL_BLK_HI  = 5;  // blank_level_sel_hi
  localparam int CTRL_HVF     = 6;  // timing_flag_out_en
  localparam int CTRL_W       = 7;  // used control bits

  // control reset value: dual-link multiplexed, standard timing
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // status field positions
  localparam int STAT_PHASE   = 0;  // two-bit sample phase
  localparam int STAT_ALIGNED = 2;  // sync edge seen since reset
  localparam int STAT_FMT     = 3;  // two-bit decoded format

  // ------------------------------------------------------------
  // decoded input formats
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_DUAL_MUX   = 2'b00,
    FMT_SINGLE_MUX = 2'b01,
    FMT_NON_MUX    = 2'b10
  } vidmx_fmt_t;

  // ------------------------------------------------------------
  // blanking levels per select code: luma, blue, red, key
  // ------------------------------------------------------------
  localparam logic [SMP_W-1:0] LVL_0   = 10'h000;
  localparam logic [SMP_W-1:0] LVL_64  = 10'h040;
  localparam logic [SMP_W-1:0] LVL_512 = 10'h200;

  localparam logic [1:0] BLK_STD  = 2'b00;  // 64,512,512,64
  localparam logic [1:0] BLK_ALL64 = 2'b01; // all 64
  localparam logic [1:0] BLK_ZERO = 2'b10;  // all 0
  localparam logic [1:0] BLK_CHR  = 2'b11;  // 0,512,512,0

  // demux phase codes
  localparam logic [1:0] PH_CB  = 2'h0;  // even blue chroma sample
  localparam logic [1:0] PH_Y0  = 2'h1;
  localparam logic [1:0] PH_CR  = 2'h2;
  localparam logic [1:0] PH_Y1  = 2'h3;  // also key slot in single link

endpackage

//--- hw/vidmx_blank.sv
// vidmx_blank: line-blanking stage forcing all four channels to a level set
`timescale 1ns/100ps
module vidmx_blank (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // control
  input  wire logic [1:0]                     level_sel,
  input  wire logic                           blank,
  // samples in
  input  wire logic                           in_valid,
  input  wire logic [vidmx_pkg::SMP_W-1:0]    in_luma,
  input  wire logic [vidmx_pkg::SMP_W-1:0]    in_blue,
  input  wire logic [vidmx_pkg::SMP_W-1:0]    in_red,
  input  wire logic [vidmx_pkg::SMP_W-1:0]    in_key,
  // samples out
  output logic                                out_valid_q,
  output logic [vidmx_pkg::SMP_W-1:0]         out_luma_q,
  output logic [vidmx_pkg::SMP_W-1:0]         out_blue_q,
  output logic [vidmx_pkg::SMP_W-1:0]         out_red_q,
  output logic [vidmx_pkg::SMP_W-1:0]         out_key_q
);

  // ------------------------------------------------------------
  // level lookup
  // ------------------------------------------------------------
  logic [vidmx_pkg::SMP_W-1:0] lvl_y;  // luma and key level
  logic [vidmx_pkg::SMP_W-1:0] lvl_c;  // chroma level

  // luma/key and chroma levels for each select code
  always_comb begin
    unique case (level_sel)
      vidmx_pkg::BLK_STD: begin
        lvl_y = vidmx_pkg::LVL_64;
        lvl_c = vidmx_pkg::LVL_512;
      end
      vidmx_pkg::BLK_ALL64: begin
        lvl_y = vidmx_pkg::LVL_64;
        lvl_c = vidmx_pkg::LVL_64;
      end
      vidmx_pkg::BLK_ZERO: begin
        lvl_y = vidmx_pkg::LVL_0;
        lvl_c = vidmx_pkg::LVL_0;
      end
      vidmx_pkg::BLK_CHR: begin
        lvl_y = vidmx_pkg::LVL_0;
        lvl_c = vidmx_pkg::LVL_512;
      end
    endcase
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  // blank replaces every channel; otherwise samples pass as they are
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_valid_q <= 1'b0;
      out_luma_q  <= 10'h000;
      out_blue_q  <= 10'h000;
      out_red_q   <= 10'h000;
      out_key_q   <= 10'h000;
    end else begin
      out_valid_q <= in_valid;
      out_luma_q  <= blank ? lvl_y : in_luma;
      out_blue_q  <= blank ? lvl_c : in_blue;
      out_red_q   <= blank ? lvl_c : in_red;
      out_key_q   <= blank ? lvl_y : in_key;
    end
  end

endmodule

//--- verification/vidmx_src_model.sv
// vidmx_src_model: upstream link logic feeding the eight data ports and sync strobe
`timescale 1ns/100ps
module vidmx_src_model (
  // clock
  input  wire logic        clk,
  // stimulus control from the bench
  input  wire logic        cyc_en,
  input  wire logic        resync,
  // first port group
  output logic [12:0]      port_p1,
  output logic [12:0]      port_p2,
  output logic [12:0]      port_p3,
  output logic [10:0]      port_p4,
  // second port group
  output logic [12:0]      port_p5,
  output logic [12:0]      port_p6,
  output logic [12:0]      port_p7,
  output logic [10:0]      port_p8,
  // demux alignment strobe
  output logic             chroma_phase_sync
);
  // sample value coded from group, lane and phase so every slot differs
  function automatic logic [9:0] val(int g, int l, int p);
    return {g[0], l[1:0], p[1:0], 5'h15};
  endfunction
  logic [1:0] ph_q   = 2'h0; // lane one slot: cb, y0, cr, y1
  logic       sync_q = 1'b1; // strobe starts high, falls once aligned
  // sync strobe and slot counter
  always_ff @(posedge clk) begin
    if (resync) begin
      sync_q <= 1'b1;
      ph_q   <= ph_q + 2'h1;
    end else if (sync_q) begin
      sync_q <= 1'b0; // falls as an even blue sample starts
      ph_q   <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1; // strobe stays low after alignment
    end
  end
  assign chroma_phase_sync = sync_q;
  // samples in bits 9..0, upper bits zero
  assign port_p1 = {3'h0, val(0, 0, cyc_en ? ph_q : 2'h0)};
  assign port_p2 = {3'h0, val(0, 1, 0)};
  assign port_p3 = {3'h0, val(0, 2, 0)};
  assign port_p4 = {1'h0, val(0, 3, 0)};
  assign port_p5 = {3'h0, val(1, 0, cyc_en ? ph_q : 2'h0)};
  assign port_p6 = {3'h0, val(1, 1, 0)};
  assign port_p7 = {3'h0, val(1, 2, 0)};
  assign port_p8 = {1'h0, val(1, 3, 0)};
endmodule

//--- verification/vidmx_checker.sv
// vidmx_checker: register port and channel checks on the front end's top ports
`timescale 1ns/100ps
module vidmx_checker (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          rstn,
  // register port
  input wire logic [vidmx_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [vidmx_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [vidmx_pkg::DATA_W-1:0]  reg_rdata_q,
  // watched inputs
  input wire logic [vidmx_pkg::PORT_W-1:0]  port_p2,
  input wire logic [vidmx_pkg::PORT_W-1:0]  port_p6,
  input wire logic                          line_blank,
  // watched outputs
  input wire logic                          ch_valid_q,
  input wire logic [vidmx_pkg::SMP_W-1:0]   ch_luma_q,
  input wire logic [vidmx_pkg::SMP_W-1:0]   ch_blue_q,
  input wire logic [vidmx_pkg::SMP_W-1:0]   ch_key_q,
  input wire logic                          timing_flag_out_en_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----
  // shadow control and settle counter
  // ----
  logic [6:0] ctl_q;   // control as last written
  logic [2:0] quiet_q; // cycles since the last control write, saturating
  logic [9:0] lvl_y;   // luma and key blanking level
  logic [9:0] lvl_c;   // chroma blanking level
  // pipeline needs several cycles after a control change to settle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl_q   <= 7'h00;
      quiet_q <= 3'h0;
    end else if (reg_wr && reg_addr == 4'h0) begin
      ctl_q   <= reg_wdata[6:0];
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  assign lvl_y = ctl_q[5] ? 10'h000 : 10'h040;
  assign lvl_c = (ctl_q[5:4] == 2'h1) ? 10'h040 : (ctl_q[5:4] == 2'h2) ? 10'h000 : 10'h200;
  // ----
  // assertions
  // ----
  rd_idle_a: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
    else $error("read data not zero outside read cycle");
  unmapped_a: assert property (reg_rd && reg_addr != 4'h0 && reg_addr != 4'h4 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  readback_a: assert property (reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
    |=> reg_rdata_q == {1'b0, $past(reg_wdata[6:0], 2)}) else $error("control readback wrong");
  flag_copy_a: assert property (reg_wr && reg_addr == 4'h0 |=> ##1 timing_flag_out_en_q == $past(reg_wdata[6], 2))
    else $error("timing flag enable not following control");
  nonmux_valid_a: assert property (ctl_q[0] && quiet_q == 3'h7 |-> ch_valid_q)
    else $error("valid not steady in non-multiplexed mode");
  mux_pulse_a: assert property (!ctl_q[0] && quiet_q == 3'h7 && ch_valid_q |=> !ch_valid_q)
    else $error("multiplexed valid longer than one cycle");
  pass_thru_a: assert property ((ctl_q[0] && quiet_q == 3'h7 && !line_blank && $stable(port_p2)
    && $stable(port_p6)) [*6] |-> ch_blue_q == (ctl_q[2] ? port_p6[9:0] : port_p2[9:0]))
    else $error("non-multiplexed sample modified");
  blank_luma_a: assert property ((line_blank && quiet_q == 3'h7) [*6] ##0 ch_valid_q
    |-> ch_luma_q == lvl_y && ch_key_q == lvl_y) else $error("luma or key blank level wrong");
  blank_chroma_a: assert property ((line_blank && quiet_q == 3'h7) [*6] ##0 ch_valid_q
    |-> ch_blue_q == lvl_c) else $error("chroma blank level wrong");
endmodule
bind vidmx_top vidmx_checker chk_u (
  .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .port_p2, .port_p6,
  .line_blank, .ch_valid_q, .ch_luma_q, .ch_blue_q, .ch_key_q, .timing_flag_out_en_q
);

//--- verification/vidmx_test.sv
// vidmx_test: self-checking bench for the input demux and blanking front end
`timescale 1ns/100ps
module vidmx_test;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       blank;
    logic [9:0] l, b, r, k;
  } vidmx_row_t;
  logic        clk, rstn, reg_wr, reg_rd, line_blank, cyc_en, resync, chroma_phase_sync;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, d;
  logic [12:0] port_p1, port_p2, port_p3, port_p5, port_p6, port_p7;
  logic [10:0] port_p4, port_p8;
  logic        ch_valid_q, timing_flag_out_en_q;
  logic [9:0]  ch_luma_q, ch_blue_q, ch_red_q, ch_key_q;
  int          n_mismatch, check_count;
  vidmx_row_t  rows [7];
  vidmx_top dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .port_p1, .port_p2,
    .port_p3, .port_p4, .port_p5, .port_p6, .port_p7, .port_p8, .chroma_phase_sync, .line_blank,
    .ch_valid_q, .ch_luma_q, .ch_blue_q, .ch_red_q, .ch_key_q, .timing_flag_out_en_q);
  vidmx_src_model src_u (.clk, .cyc_en, .resync, .port_p1, .port_p2, .port_p3, .port_p4, .port_p5,
    .port_p6, .port_p7, .port_p8, .chroma_phase_sync);
  function automatic logic [9:0] val(int g, int l, int p);
    return {g[0], l[1:0], p[1:0], 5'h15};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string nm, logic [9:0] exp, logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // register tasks are entered just after a clock edge
  task automatic wr(logic [3:0] a, logic [7:0] v);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  // bounded wait for a valid channel word
  task automatic wait_valid();
    int i;
    for (i = 0; i < 20 && ch_valid_q !== 1'b1; i++) @(posedge clk) #1;
    if (i == 20) begin
      n_mismatch++;
      $display("BAD valid exp 1 got 0");
      end_sim();
    end
  endtask
  // align with a sync fall and check four multiplexed words
  task automatic mux_run(logic [7:0] c, int g, logic single);
    logic [9:0] y;
    wr(4'h0, c);
    cyc_en <= 1'b1;
    resync <= 1'b1;
    repeat (3) @(posedge clk);
    resync <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    for (int n = 0; n < 4; n++) begin
      wait_valid();
      if (single) y = val(g, 0, 1);
      else if (n == 0) y = (ch_luma_q === val(g, 0, 3)) ? val(g, 0, 3) : val(g, 0, 1);
      else y = (y === val(g, 0, 1)) ? val(g, 0, 3) : val(g, 0, 1);
      check("mux luma", y, ch_luma_q);
      check("mux blue", val(g, 0, 0), ch_blue_q);
      check("mux red", val(g, 0, 2), ch_red_q);
      check("mux key", single ? val(g, 0, 3) : val(g, 3, 0), ch_key_q);
      @(posedge clk) #1;
    end
    rd(4'h4);
    check("status", {5'h0, 1'b0, single, 1'b1, 2'h0}, {d[4:2], 2'h0});
    cyc_en <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, reg_wr, reg_rd, line_blank, cyc_en, resync, reg_addr, reg_wdata} = '0;
    rows = '{'{8'h01, 1'b0, val(0, 0, 0), val(0, 1, 0), val(0, 2, 0), val(0, 3, 0)},
             '{8'h05, 1'b0, val(1, 0, 0), val(1, 1, 0), val(1, 2, 0), val(1, 3, 0)},
             '{8'h03, 1'b0, val(0, 0, 0), val(0, 1, 0), val(0, 2, 0), val(0, 3, 0)},
             '{8'h01, 1'b1, 10'h040, 10'h200, 10'h200, 10'h040},
             '{8'h11, 1'b1, 10'h040, 10'h040, 10'h040, 10'h040},
             '{8'h21, 1'b1, 10'h000, 10'h000, 10'h000, 10'h000},
             '{8'h31, 1'b1, 10'h000, 10'h200, 10'h200, 10'h000}};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(4'h0);
    check("ctrl reset", 10'h000, d);
    foreach (rows[i]) begin
      wr(4'h0, rows[i].ctrl);
      line_blank <= rows[i].blank;
      repeat (8) @(posedge clk);
      #1;
      check("valid", 10'h001, ch_valid_q);
      check("luma", rows[i].l, ch_luma_q);
      check("blue", rows[i].b, ch_blue_q);
      check("red", rows[i].r, ch_red_q);
      check("key", rows[i].k, ch_key_q);
      rd(4'h4);
      check("format", {rows[i].ctrl[0], !rows[i].ctrl[0] & rows[i].ctrl[1]}, d[4:3]);
    end
    line_blank <= 1'b0;
    mux_run(8'h00, 0, 1'b0);
    mux_run(8'h04, 1, 1'b0);
    mux_run(8'h02, 0, 1'b1);
    // write then read back to back, status write ignored, unmapped read
    wr(4'h0, 8'h41);
    rd(4'h0);
    check("ctrl back", 10'h041, d);
    wr(4'h4, 8'hFF);
    rd(4'h0);
    check("status write", 10'h041, d);
    check("flag out", 10'h001, timing_flag_out_en_q);
    rd(4'h8);
    check("unmapped", 10'h000, d);
    // reset in mid-run clears outputs and control
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rst valid", 10'h000, ch_valid_q);
    check("rst luma", 10'h000, ch_luma_q);
    rstn <= 1'b1;
    @(posedge clk);
    rd(4'h0);
    check("ctrl rst2", 10'h000, d);
    end_sim();
  end
endmodule
